/* core/spl_pkg.sv */
package spl_pkg;
   // Register offsets (byte addresses in the port's register space)
   localparam logic [11:0] OFS_DEBUG_CTRL = 12'h1dc;
   localparam logic [11:0] OFS_PHP_CFG = 12'h1e0;
   localparam logic [11:0] OFS_EGRESS = 12'h1e4;
   localparam logic [11:0] OFS_BAD_TLP = 12'h1e8;
   localparam logic [11:0] OFS_BAD_DLLP = 12'h1ec;
   localparam logic [11:0] OFS_RELAX_ORD = 12'h1f0;
   localparam logic [11:0] OFS_SW_LANE = 12'h1f4;
   localparam logic [11:0] OFS_ACK_REPLAY = 12'h1f8;
   localparam logic [11:0] OFS_LANE_MASKS = 12'h204;
   localparam logic [11:0] OFS_DESKEW_LO = 12'h208;

   // Lanes: 11 positions, 5, 7 and 9 unused (lane 11 lies outside)
   localparam int LANE_NUM = 11;
   localparam logic [10:0] LANE_USED = 11'h55f;

   // Debug control
   localparam int DBG_LANE_OVR_BIT = 30;

   // Power management hot plug user configuration
   localparam logic [31:0] PHP_RESET = 32'h0000_0040;
   localparam logic [31:0] PHP_SW_MASK = 32'h0000_1f87;
   localparam logic [31:0] PHP_EE_MASK = 32'h0000_1fff;
   localparam int PHP_SLOT_DLY_BIT = 6;

   // Egress control and status
   localparam int EGR_EN_BIT = 0;
   localparam int EGR_SEL_BIT = 1;
   localparam int EGR_RW_W = 16;
   localparam int EGR_CT_LSB = 16;
   localparam int EGR_SOFT_LSB = 24;
   localparam logic [3:0] CT_MAX_CODE = 4'h5;

   // Relaxed ordering enable
   localparam int RO_EN_BIT = 20;

   // ACK latency / replay limit register
   localparam int ACK_LSB = 0;
   localparam int FACT_LSB = 8;
   localparam int REPLAY_LSB = 16;
   localparam logic [7:0] ACK_RESET = 8'hff;
   localparam logic [7:0] FACT_RESET = 8'h00;
   localparam logic [7:0] REPLAY_RESET = 8'hff;
   localparam logic [7:0] ACK_X1 = 8'hff;
   localparam logic [7:0] ACK_X2 = 8'hd9;
   localparam logic [7:0] ACK_X4 = 8'h76;
   localparam logic [7:0] REPLAY_X1 = 8'h05;
   localparam logic [7:0] REPLAY_X2 = 8'h03;
   localparam logic [7:0] REPLAY_X4 = 8'h02;

   // Lane masks and deskew
   localparam int RXD_MASK_LSB = 16;
   localparam int DSK_LANES = 4;
   localparam int DSK_STRIDE = 4;
   localparam int DSK_LEVEL_W = 3;
   localparam logic [7:0] CNT_MAX = 8'hff;

   // Egress timeout window, minimum side of each setting
   localparam int CLK_HZ = 10_000_000;
   localparam int EGR_TMO0_MS = 512;
   localparam int EGR_TMO1_MS = 1024;
   localparam logic [23:0] EGR_TMO0_CYC =
      24'(EGR_TMO0_MS * (CLK_HZ / 1000));
   localparam logic [23:0] EGR_TMO1_CYC =
      24'(EGR_TMO1_MS * (CLK_HZ / 1000));

   typedef enum logic [1:0] {WID_X1, WID_X2, WID_X4} spl_width_t;

   // Register access: config software or serial EEPROM loader
   typedef struct packed {
      logic wr;
      logic rd;
      logic eeprom;
      logic [11:0] addr;
      logic [31:0] wdata;
   } spl_cfg_req_t;

   typedef struct packed {
      logic up;
      logic eeprom_present;
      spl_width_t width;
   } spl_link_t;

   // One-cycle events and levels from the data path
   typedef struct packed {
      logic bad_tlp;
      logic bad_dllp;
      logic ram_soft_err;
      logic credit_update;
      logic egress_stalled;
      logic [3:0] stall_ct;
   } spl_event_t;
endpackage : spl_pkg

/* core/spl_deskew_lane.sv */
`timescale 1ns/1ps
module spl_deskew_lane
   import spl_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire logic i_manual_en,
   input wire logic [DSK_LEVEL_W-1:0] i_prog_level,
   input wire logic [DSK_LEVEL_W-1:0] i_auto_level,
   output logic [DSK_LEVEL_W-1:0] o_level
);
   typedef struct packed {
      logic [DSK_LEVEL_W-1:0] level;
   } spl_dsk_state_t;

   spl_dsk_state_t st;
   spl_dsk_state_t next_st;

   // Manual value wins only while enabled; else follow the auto engine
   always_comb begin
      next_st = st;
      next_st.level = i_manual_en ? i_prog_level : i_auto_level;
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= '0;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   assign o_level = st.level;
endmodule : spl_deskew_lane

/* core/spl_regs.sv */
`timescale 1ns/1ps
module spl_regs
   import spl_pkg::*;
#(
   parameter logic [23:0] TMO0_CYC = EGR_TMO0_CYC,
   parameter logic [23:0] TMO1_CYC = EGR_TMO1_CYC
)
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire spl_cfg_req_t i_cfg,
   input wire spl_link_t i_link,
   input wire spl_event_t i_evt,
   input wire logic [LANE_NUM-1:0] i_lane_up,
   input wire logic [DSK_LANES*DSK_LEVEL_W-1:0] i_auto_deskew,
   input wire logic i_cpl_head,
   input wire logic i_posted_older,
   output logic [31:0] o_cfg_rdata,
   output logic o_cfg_rvalid,
   output logic o_link_down,
   output logic o_cpl_go,
   output logic [LANE_NUM-1:0] o_lane_good_n,
   output logic [7:0] o_ack_latency_limit,
   output logic [7:0] o_replay_limit_hi,
   output logic [LANE_NUM-1:0] o_idle_mask,
   output logic [LANE_NUM-1:0] o_rxdet_mask,
   output logic [DSK_LANES-1:0] o_deskew_manual,
   output logic [DSK_LANES*DSK_LEVEL_W-1:0] o_deskew_level,
   output logic o_slot_reset_100ms
);
   typedef struct packed {
      logic lane_ovr;
      logic [31:0] php;
      logic [EGR_RW_W-1:0] egr_rw;
      logic [3:0] egr_ct;
      logic [7:0] soft_cnt;
      logic [7:0] bad_tlp;
      logic [7:0] bad_dllp;
      logic ro_en;
      logic [LANE_NUM-1:0] sw_lane;
      logic [LANE_NUM-1:0] lane_good_n;
      logic [7:0] ack;
      logic [7:0] fact;
      logic [7:0] replay;
      logic [LANE_NUM-1:0] idle_mask;
      logic [LANE_NUM-1:0] rxd_mask;
      logic [15:0] dsk;
      logic [23:0] egr_cnt;
      logic link_down;
      logic link_up_d;
      logic [31:0] rdata;
      logic rvalid;
   } spl_state_t;

   localparam spl_state_t ST_RESET = '{
      php: PHP_RESET,
      ack: ACK_RESET,
      fact: FACT_RESET,
      replay: REPLAY_RESET,
      lane_good_n: '1,
      default: '0
   };

   spl_state_t st;
   spl_state_t next_st;
   logic [DSK_LANES*DSK_LEVEL_W-1:0] eff_level;

   // Counter step that holds at the top instead of wrapping
   function automatic logic [7:0] sat_inc(input logic [7:0] v);
      sat_inc = (v == CNT_MAX) ? v : v + 8'h01;
   endfunction : sat_inc

   // Replace only the bits that the mask lets through
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction : merge

   // Write strobe for one register offset
   function automatic logic hit(input spl_cfg_req_t r,
                                input logic [11:0] ofs);
      hit = r.wr && (r.addr == ofs);
   endfunction : hit

   function automatic logic [7:0] ack_for(input spl_width_t w);
      unique case (w)
         WID_X1: ack_for = ACK_X1;
         WID_X2: ack_for = ACK_X2;
         WID_X4: ack_for = ACK_X4;
         default: ack_for = ACK_X1;
      endcase
   endfunction : ack_for

   function automatic logic [7:0] replay_for(input spl_width_t w);
      unique case (w)
         WID_X1: replay_for = REPLAY_X1;
         WID_X2: replay_for = REPLAY_X2;
         WID_X4: replay_for = REPLAY_X4;
         default: replay_for = REPLAY_X1;
      endcase
   endfunction : replay_for

   // Deskew fields as seen on reads: effective level plus manual enable
   function automatic logic [15:0] dsk_view(
         input logic [15:0] d,
         input logic [DSK_LANES*DSK_LEVEL_W-1:0] lvl);
      logic [15:0] v;
      v = d;
      for (int i = 0; i < DSK_LANES; i++) begin
         v[i*DSK_STRIDE +: DSK_LEVEL_W] = lvl[i*DSK_LEVEL_W +: DSK_LEVEL_W];
      end
      dsk_view = v;
   endfunction : dsk_view

   // Per-lane deskew selection, lanes 0 to 3
   for (genvar g = 0; g < DSK_LANES; g++) begin : g_dsk
      spl_deskew_lane u_lane (
         .i_clk_sys(i_clk_sys),
         .i_rstn(i_rstn),
         .i_ce(i_ce),
         .i_manual_en(st.dsk[g*DSK_STRIDE+DSK_LEVEL_W]),
         .i_prog_level(st.dsk[g*DSK_STRIDE +: DSK_LEVEL_W]),
         .i_auto_level(i_auto_deskew[g*DSK_LEVEL_W +: DSK_LEVEL_W]),
         .o_level(eff_level[g*DSK_LEVEL_W +: DSK_LEVEL_W])
      );
   end

   // Next-state logic: software writes first, hardware updates after
   always_comb begin
      logic [31:0] wd;
      logic [31:0] dsk_mask;
      logic [23:0] limit;
      wd = i_cfg.wdata;
      dsk_mask = '0;
      limit = '0;
      next_st = st;
      next_st.link_down = 1'b0;
      next_st.rvalid = 1'b0;
      next_st.link_up_d = i_link.up;

      for (int i = 0; i < DSK_LANES; i++) begin
         dsk_mask[i*DSK_STRIDE +: DSK_STRIDE] = '1;
      end

      // Register writes
      if (hit(i_cfg, OFS_DEBUG_CTRL)) begin
         next_st.lane_ovr = wd[DBG_LANE_OVR_BIT];
      end
      // Hot plug timing bits are loader-only; software sees them RO
      if (hit(i_cfg, OFS_PHP_CFG)) begin
         next_st.php = merge(st.php, wd,
            i_cfg.eeprom ? PHP_EE_MASK : PHP_SW_MASK);
      end
      if (hit(i_cfg, OFS_EGRESS)) begin
         next_st.egr_rw = wd[EGR_RW_W-1:0];
      end
      if (hit(i_cfg, OFS_RELAX_ORD)) begin
         next_st.ro_en = wd[RO_EN_BIT];
      end
      if (hit(i_cfg, OFS_SW_LANE) && st.lane_ovr) begin
         next_st.sw_lane = wd[LANE_NUM-1:0] & LANE_USED;
      end
      // EEPROM image supplies its own width-matched limits
      if (hit(i_cfg, OFS_ACK_REPLAY)) begin
         next_st.ack = wd[ACK_LSB +: 8];
         next_st.fact = wd[FACT_LSB +: 8];
         next_st.replay = wd[REPLAY_LSB +: 8];
      end
      if (hit(i_cfg, OFS_LANE_MASKS)) begin
         next_st.idle_mask = wd[LANE_NUM-1:0] & LANE_USED;
         next_st.rxd_mask =
            wd[RXD_MASK_LSB +: LANE_NUM] & LANE_USED;
      end
      if (hit(i_cfg, OFS_DESKEW_LO)) begin
         next_st.dsk =
            16'(merge({16'h0000, st.dsk}, wd, dsk_mask));
      end

      // Bad packet counters: a write loads, an event in the same cycle
      // still counts on top of the loaded value
      if (hit(i_cfg, OFS_BAD_TLP)) begin
         next_st.bad_tlp = wd[7:0];
      end
      if (hit(i_cfg, OFS_BAD_DLLP)) begin
         next_st.bad_dllp = wd[7:0];
      end
      if (i_evt.bad_tlp) begin
         next_st.bad_tlp = sat_inc(next_st.bad_tlp);
      end
      if (i_evt.bad_dllp) begin
         next_st.bad_dllp = sat_inc(next_st.bad_dllp);
      end
      // Soft error count is read-only and simply steps on each event
      if (i_evt.ram_soft_err) begin
         next_st.soft_cnt = st.soft_cnt + 8'h01;
      end

      // Width-based limits on link-up when no EEPROM loaded them.
      // Link is a plain up/down pair, no crossed configuration roles.
      if (i_link.up && !st.link_up_d && !i_link.eeprom_present) begin
         next_st.ack = ack_for(i_link.width);
         next_st.replay = replay_for(i_link.width);
      end

      // Egress credit timer; restarts on any credit or when not stalled.
      // Firing at the minimum keeps it inside either documented window.
      limit = st.egr_rw[EGR_SEL_BIT] ? TMO1_CYC : TMO0_CYC;
      if (!st.egr_rw[EGR_EN_BIT] || !i_evt.egress_stalled
          || i_evt.credit_update) begin
         next_st.egr_cnt = '0;
      end else if (st.egr_cnt >= limit - 24'h000001) begin
         next_st.egr_cnt = '0;
         next_st.link_down = 1'b1;
         if (i_evt.stall_ct <= CT_MAX_CODE) begin
            next_st.egr_ct = i_evt.stall_ct;
         end
      end else begin
         next_st.egr_cnt = st.egr_cnt + 24'h000001;
      end

      // Lane-good pins are active low; unused lanes stay inactive.
      // While pins follow the PHY, the shadow tracks them so that
      // handing control to software causes no glitch.
      if (next_st.lane_ovr) begin
         next_st.lane_good_n = ~(next_st.sw_lane & LANE_USED);
      end else begin
         next_st.lane_good_n = ~(i_lane_up & LANE_USED);
         next_st.sw_lane = ~st.lane_good_n & LANE_USED;
      end

      // Read port, answered one cycle later; unmapped reads give zero
      if (i_cfg.rd) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = '0;
         unique case (i_cfg.addr)
            OFS_DEBUG_CTRL: next_st.rdata[DBG_LANE_OVR_BIT] = st.lane_ovr;
            OFS_PHP_CFG: next_st.rdata = st.php;
            OFS_EGRESS: begin
               next_st.rdata[EGR_RW_W-1:0] = st.egr_rw;
               next_st.rdata[EGR_CT_LSB +: 4] = st.egr_ct;
               next_st.rdata[EGR_SOFT_LSB +: 8] = st.soft_cnt;
            end
            OFS_BAD_TLP: next_st.rdata[7:0] = st.bad_tlp;
            OFS_BAD_DLLP: next_st.rdata[7:0] = st.bad_dllp;
            OFS_RELAX_ORD: next_st.rdata[RO_EN_BIT] = st.ro_en;
            OFS_SW_LANE: begin
               next_st.rdata[LANE_NUM-1:0] = st.lane_ovr ? st.sw_lane
                  : (st.lane_good_n & LANE_USED);
            end
            OFS_ACK_REPLAY: begin
               next_st.rdata[ACK_LSB +: 8] = st.ack;
               next_st.rdata[FACT_LSB +: 8] = st.fact;
               next_st.rdata[REPLAY_LSB +: 8] = st.replay;
            end
            OFS_LANE_MASKS: begin
               next_st.rdata[LANE_NUM-1:0] = st.idle_mask;
               next_st.rdata[RXD_MASK_LSB +: LANE_NUM] = st.rxd_mask;
            end
            OFS_DESKEW_LO: begin
               next_st.rdata[15:0] = dsk_view(st.dsk, eff_level);
            end
            default: next_st.rdata = '0;
         endcase
      end
   end

   // State register; the clock enable freezes everything
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         st <= ST_RESET;
      end else if (i_ce) begin
         st <= next_st;
      end
   end

   // Completion may go unless an older posted TLP blocks it
   assign o_cpl_go = i_cpl_head && (st.ro_en || !i_posted_older);

   // Outputs straight from the state register
   always_comb begin
      o_cfg_rdata = st.rdata;
      o_cfg_rvalid = st.rvalid;
      o_link_down = st.link_down;
      o_lane_good_n = st.lane_good_n;
      o_ack_latency_limit = st.ack;
      o_replay_limit_hi = st.replay;
      o_idle_mask = st.idle_mask;
      o_rxdet_mask = st.rxd_mask;
      o_deskew_level = eff_level;
      o_slot_reset_100ms = st.php[PHP_SLOT_DLY_BIT];
      for (int i = 0; i < DSK_LANES; i++) begin
         o_deskew_manual[i] = st.dsk[i*DSK_STRIDE+DSK_LEVEL_W];
      end
   end
endmodule : spl_regs

/* sim/spl_regs_monitor.sv */
`timescale 1ns/1ps
module spl_regs_monitor
   import spl_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_ce,
   input wire spl_cfg_req_t i_cfg,
   input wire spl_link_t i_link,
   input wire spl_event_t i_evt,
   input wire logic i_cpl_head,
   input wire logic i_posted_older,
   input wire logic o_cfg_rvalid,
   input wire logic o_link_down,
   input wire logic o_cpl_go,
   input wire logic [LANE_NUM-1:0] o_lane_good_n,
   input wire logic [7:0] o_ack_latency_limit,
   input wire logic [7:0] o_replay_limit_hi,
   input wire logic [LANE_NUM-1:0] o_idle_mask,
   input wire logic [LANE_NUM-1:0] o_rxdet_mask
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);

   // Width table, replay byte above ack byte
   function automatic logic [15:0] lim(input spl_width_t w);
      case (w)
         WID_X1: lim = {REPLAY_X1, ACK_X1};
         WID_X2: lim = {REPLAY_X2, ACK_X2};
         default: lim = {REPLAY_X4, ACK_X4};
      endcase
   endfunction : lim

   // A taken read and a taken link rise
   sequence s_rd;
      i_ce && i_cfg.rd;
   endsequence
   sequence s_rise;
      i_ce && $rose(i_link.up) && !i_link.eeprom_present;
   endsequence

   chk_read_answer: assert property (s_rd |=> o_cfg_rvalid)
      else $error("read not answered next cycle");
   chk_rvalid_cause: assert property (o_cfg_rvalid |-> $past(i_ce && i_cfg.rd))
      else $error("read valid without a read");
   chk_down_pulse: assert property (o_link_down |=> !o_link_down)
      else $error("link down longer than one cycle");
   chk_down_cause: assert property (o_link_down |->
      $past(i_evt.egress_stalled))
      else $error("link down without a stall");
   chk_cpl_strict: assert property (i_cpl_head && !i_posted_older
      |-> o_cpl_go)
      else $error("completion held with nothing older");
   chk_cpl_idle: assert property (!i_cpl_head |-> !o_cpl_go)
      else $error("completion released without one");
   chk_unused_lanes: assert property (
      (o_lane_good_n & ~LANE_USED) == ~LANE_USED)
      else $error("unused lane reported good");
   chk_mask_unused: assert property (
      ((o_idle_mask | o_rxdet_mask) & ~LANE_USED) == '0)
      else $error("mask set on unused lane");
   chk_width_limits: assert property (s_rise |=>
      {o_replay_limit_hi, o_ack_latency_limit}
         == lim($past(i_link.width)))
      else $error("limits not loaded from width");
endmodule : spl_regs_monitor

bind spl_regs spl_regs_monitor mon (
   .i_clk_sys(i_clk_sys),
   .i_rstn(i_rstn),
   .i_ce(i_ce),
   .i_cfg(i_cfg),
   .i_link(i_link),
   .i_evt(i_evt),
   .i_cpl_head(i_cpl_head),
   .i_posted_older(i_posted_older),
   .o_cfg_rvalid(o_cfg_rvalid),
   .o_link_down(o_link_down),
   .o_cpl_go(o_cpl_go),
   .o_lane_good_n(o_lane_good_n),
   .o_ack_latency_limit(o_ack_latency_limit),
   .o_replay_limit_hi(o_replay_limit_hi),
   .o_idle_mask(o_idle_mask),
   .o_rxdet_mask(o_rxdet_mask)
);

/* sim/spl_far_end.sv */
`timescale 1ns/1ps
module spl_far_end
   import spl_pkg::*;
(
   input wire logic i_clk_sys,
   output spl_event_t o_evt,
   output spl_link_t o_link,
   output logic [LANE_NUM-1:0] o_lane_up,
   output logic [DSK_LANES*DSK_LEVEL_W-1:0] o_auto_deskew
);
   // Quiet link, no loader fitted
   initial begin
      o_evt = '0;
      o_link = '{up: 1'b0, eeprom_present: 1'b0, width: WID_X1};
      o_lane_up = '0;
      o_auto_deskew = 12'h0d1;
   end
   // Back-to-back error pulses to stress the counters
   task automatic errs(input int kind, input int n);
      repeat (n) begin
         @(posedge i_clk_sys);
         o_evt.bad_tlp <= (kind == 0);
         o_evt.bad_dllp <= (kind == 1);
         o_evt.ram_soft_err <= (kind == 2);
      end
      @(posedge i_clk_sys);
      o_evt.bad_tlp <= 1'b0;
      o_evt.bad_dllp <= 1'b0;
      o_evt.ram_soft_err <= 1'b0;
   endtask : errs
   // Credits withheld for n cycles; one credit after cycle cr if 0 <= cr < n - 1
   task automatic stall(input logic [3:0] ct, input int n,
                        input int cr = -1);
      @(posedge i_clk_sys);
      o_evt.egress_stalled <= 1'b1;
      o_evt.stall_ct <= ct;
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk_sys);
         o_evt.credit_update <= (i == cr) && (i < n - 1);
      end
      o_evt.egress_stalled <= 1'b0;
   endtask : stall
   // Retrain; one low cycle so the rise is seen
   task automatic train(input spl_width_t w);
      @(posedge i_clk_sys);
      o_link.up <= 1'b0;
      @(posedge i_clk_sys);
      o_link.up <= 1'b1;
      o_link.width <= w;
      o_lane_up <= '1;
      @(posedge i_clk_sys);
   endtask : train
endmodule : spl_far_end

/* sim/spl_regs_test.sv */
`timescale 1ns/1ps
module spl_regs_test;
   import spl_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rstn = 1'b0;
   spl_cfg_req_t cfg = '0;
   logic head = 1'b0;
   logic older = 1'b0;
   logic ce = 1'b1;
   spl_event_t evt;
   spl_link_t lnk;
   logic [10:0] lane_up, lgn, imask, rmask;
   logic [11:0] adsk, dlvl;
   logic [31:0] rdata;
   logic rvalid, ldn, go, slot;
   logic [7:0] ack, rep;
   logic [3:0] dman;
   int bad_count = 0;
   int n_checks = 0;
   int n_dn = 0;
   spl_width_t wl[3] = '{WID_X1, WID_X2, WID_X4};
   logic [7:0] al[3] = '{ACK_X1, ACK_X2, ACK_X4};
   logic [7:0] rl[3] = '{REPLAY_X1, REPLAY_X2, REPLAY_X4};

   always #50 i_clk_sys = ~i_clk_sys;

   // Short timeout windows keep the run brief
   spl_regs #(.TMO0_CYC(24'd8), .TMO1_CYC(24'd16)) dut (
      .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(ce), .i_cfg(cfg),
      .i_link(lnk), .i_evt(evt), .i_lane_up(lane_up),
      .i_auto_deskew(adsk), .i_cpl_head(head), .i_posted_older(older),
      .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .o_link_down(ldn),
      .o_cpl_go(go), .o_lane_good_n(lgn), .o_ack_latency_limit(ack),
      .o_replay_limit_hi(rep), .o_idle_mask(imask), .o_rxdet_mask(rmask),
      .o_deskew_manual(dman), .o_deskew_level(dlvl),
      .o_slot_reset_100ms(slot));
   spl_far_end far (.i_clk_sys(i_clk_sys), .o_evt(evt), .o_link(lnk),
      .o_lane_up(lane_up), .o_auto_deskew(adsk));

   // Pulses are one cycle wide, so count per edge
   always @(posedge i_clk_sys) if (ldn === 1'b1) n_dn++;

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic ee = 1'b0);
      @(posedge i_clk_sys);
      cfg <= '{wr: 1'b1, rd: 1'b0, eeprom: ee, addr: a, wdata: d};
      @(posedge i_clk_sys);
      cfg.wr <= 1'b0;
   endtask : wr
   // Answer is due exactly one cycle after the taking edge
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge i_clk_sys);
      cfg.rd <= 1'b1;
      cfg.addr <= a;
      @(posedge i_clk_sys);
      cfg.rd <= 1'b0;
      @(negedge i_clk_sys);
      chk("rvalid", 32'h1, {31'h0, rvalid});
      chk($sformatf("reg %h", a), e, rdata);
   endtask : rd
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results

   // Hang guard
   initial begin
      repeat (20000) @(posedge i_clk_sys);
      bad_count++;
      results();
   end

   initial begin
      repeat (10) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      rd(OFS_ACK_REPLAY, 32'h00ff_00ff);
      rd(OFS_PHP_CFG, PHP_RESET);
      rd(12'h300, 32'h0);
      // Counters: resume from written value, then saturate
      wr(OFS_BAD_TLP, 32'hffff_ff10);
      far.errs(0, 3);
      rd(OFS_BAD_TLP, 32'h0000_0013);
      far.errs(0, 240);
      rd(OFS_BAD_TLP, 32'h0000_00ff);
      wr(OFS_BAD_DLLP, 32'h0000_00fe);
      far.errs(1, 4);
      rd(OFS_BAD_DLLP, 32'h0000_00ff);
      // Events while the clock enable is low must not count
      @(posedge i_clk_sys);
      ce <= 1'b0;
      far.errs(2, 2);
      @(posedge i_clk_sys);
      ce <= 1'b1;
      far.errs(2, 3);
      wr(OFS_EGRESS, 32'h0000_0003);
      rd(OFS_EGRESS, 32'h0300_0003);
      // Egress timer: long window, then short window with a reserved code
      far.stall(4'h4, 12);
      chk("link down", 32'd0, 32'(n_dn));
      far.stall(4'h4, 20);
      chk("link down", 32'd1, 32'(n_dn));
      rd(OFS_EGRESS, 32'h0304_0003);
      wr(OFS_EGRESS, 32'h0000_0001);
      far.stall(4'h7, 12);
      chk("link down", 32'd2, 32'(n_dn));
      rd(OFS_EGRESS, 32'h0304_0001);
      // A credit in mid-stall restarts the window
      far.stall(4'h2, 12, 5);
      chk("link down", 32'd2, 32'(n_dn));
      wr(OFS_EGRESS, 32'h0);
      far.stall(4'h2, 20);
      chk("link down", 32'd2, 32'(n_dn));
      // Completion with nothing older, then behind an older posted one
      @(posedge i_clk_sys);
      head <= 1'b1;
      @(negedge i_clk_sys);
      chk("cpl go", 32'h1, {31'h0, go});
      @(posedge i_clk_sys);
      older <= 1'b1;
      @(negedge i_clk_sys);
      chk("cpl go", 32'h0, {31'h0, go});
      wr(OFS_RELAX_ORD, 32'hffff_ffff);
      rd(OFS_RELAX_ORD, 32'h0010_0000);
      chk("cpl go", 32'h1, {31'h0, go});
      for (int i = 0; i < 3; i++) begin
         far.train(wl[i]);
         rd(OFS_ACK_REPLAY, {8'h0, rl[i], 8'h0, al[i]});
      end
      // Lane good echo, then software control
      chk("lane good", 32'h2a0, {21'h0, lgn});
      wr(OFS_SW_LANE, 32'h0000_0141);
      rd(OFS_SW_LANE, 32'h0);
      wr(OFS_DEBUG_CTRL, 32'hffff_ffff);
      rd(OFS_DEBUG_CTRL, 32'h4000_0000);
      wr(OFS_SW_LANE, 32'hffff_0141);
      rd(OFS_SW_LANE, 32'h0000_0141);
      chk("lane good", 32'h6be, {21'h0, lgn});
      wr(OFS_LANE_MASKS, 32'hffff_ffff);
      rd(OFS_LANE_MASKS, 32'h055f_055f);
      chk("masks", 32'h055f_055f, {5'h0, rmask, 5'h0, imask});
      // Loader image with factory bits kept clear
      wr(OFS_ACK_REPLAY, 32'h0005_00fa, 1'b1);
      rd(OFS_ACK_REPLAY, 32'h0005_00fa);
      chk("limits", 32'h05fa, {16'h0, rep, ack});
      wr(OFS_PHP_CFG, 32'h0000_0007, 1'b1);
      rd(OFS_PHP_CFG, 32'h0000_0007);
      chk("slot delay", 32'h0, {31'h0, slot});
      wr(OFS_PHP_CFG, 32'h0000_0040);
      rd(OFS_PHP_CFG, 32'h0);
      // Lanes 1 and 3 manual, 0 and 2 automatic
      wr(OFS_DESKEW_LO, 32'hffff_e7d7);
      rd(OFS_DESKEW_LO, 32'h0000_e3d1);
      chk("deskew", 32'h0000_ace9, {16'h0, dman, dlvl});
      results();
   end
endmodule : spl_regs_test
